// file: verilog/jlur_defines.svh
// Purpose: Offsets, field positions, reset values and counts
// Assumes: Byte addresses on a 32-bit AXI4-Lite bus
// Notes:   Definitions only
`ifndef JLUR_DEFINES_SVH
`define JLUR_DEFINES_SVH
`define JLUR_A_CTRL      8'h00
`define JLUR_A_CFG       8'h04
`define JLUR_A_PER       8'h08
`define JLUR_A_STAT      8'h0C
`define JLUR_A_ISTAT     8'h10
`define JLUR_A_IMASK     8'h14
`define JLUR_CTRL_EN     0
`define JLUR_CTRL_RSYNC  1
`define JLUR_CTRL_TAIL   2
`define JLUR_CTRL_PERIOD 3
`define JLUR_CTRL_PHREQ  4
`define JLUR_CTRL_NCO    5
`define JLUR_IRQ_RESYNC  0
`define JLUR_IRQ_REINIT  1
`define JLUR_IRQ_MISPL   2
`define JLUR_IRQ_MISS    3
`define JLUR_IRQ_PHUP    4
`define JLUR_CTRL_RST    6'h08
`define JLUR_CFG_RST     13'h1F03
`define JLUR_PER_RST     16'h07FF
`define JLUR_IMASK_RST   5'h00
`define JLUR_CGS_CNT     3'h4
`define JLUR_ERR_LIMIT   2'h2
`define JLUR_K28_5       8'hBC
`define JLUR_K28_3       8'h7C
`define JLUR_K28_7       8'hFC
`define JLUR_TAIL_OK     4'h0
`define JLUR_RESP_OK     2'h0
`define JLUR_RESP_ERR    2'h2
`endif

// file: verilog/jlur_pkg.sv
// Purpose: Types and shared helpers of the link upset-recovery controller
// Assumes: Constants come from jlur_defines.svh
// Notes:   State of every module is one packed struct
`include "jlur_defines.svh"
package jlur_pkg;
   typedef enum logic [3:0] {
      JLUR_ST_IDLE = 4'b0001,
      JLUR_ST_CGS  = 4'b0010,
      JLUR_ST_ILAS = 4'b0100,
      JLUR_ST_DATA = 4'b1000
   } jlur_state_type;

   typedef struct packed {
      logic        awv;
      logic [7:0]  awaddr;
      logic        wv;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [5:0]  ctrl;
      logic [12:0] cfg;
      logic [15:0] per;
      logic [4:0]  istat;
      logic [4:0]  imask;
      logic [2:0]  pu_sy;
      logic        pu_lvl;
      logic        nco_reinit;
   } jlur_top_st_type;

   typedef struct packed {
      jlur_state_type state;
      logic           sync_n;
      logic [2:0]     cgs_cnt;
      logic [7:0]     oct;
      logic [4:0]     frm;
      logic [1:0]     err_cnt;
      logic [3:0]     ev;
   } jlur_mon_st_type;

   typedef struct packed {
      logic [15:0] cnt;
      logic        trig_d;
      logic        out;
   } jlur_sref_st_type;

   // Byte-lane merge of a write into an old value
   function automatic logic [31:0] jlur_merge(input logic [31:0] o,
                                              input logic [31:0] d,
                                              input logic [3:0]  s);
      logic [31:0] m;
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      return (o & ~m) | (d & m);
   endfunction : jlur_merge

   // Register index of a byte address, 7 when unmapped
   function automatic logic [2:0] jlur_reg_idx(input logic [7:0] a);
      if (a == `JLUR_A_CTRL) return 3'h0;
      else if (a == `JLUR_A_CFG) return 3'h1;
      else if (a == `JLUR_A_PER) return 3'h2;
      else if (a == `JLUR_A_STAT) return 3'h3;
      else if (a == `JLUR_A_ISTAT) return 3'h4;
      else if (a == `JLUR_A_IMASK) return 3'h5;
      else return 3'h7;
   endfunction : jlur_reg_idx

   // Control character match
   function automatic logic jlur_is_code(input logic k,
                                         input logic [7:0] d,
                                         input logic [7:0] c);
      return k && (d == c);
   endfunction : jlur_is_code
endpackage : jlur_pkg

// file: verilog/jlur_mon_if.sv
// Purpose: Carrier between register block and alignment monitor
// Assumes: Both ends on aclk
// Notes:   No clocking block
`timescale 1ns/1ps
interface jlur_mon_if;
   import jlur_pkg::*;
   logic [7:0]     frame_len_m1;
   logic [4:0]     mf_len_m1;
   logic           tail_en;
   logic           link_en;
   logic           force_resync;
   jlur_state_type state;
   logic           sync_n;
   logic [1:0]     err_cnt;
   logic [3:0]     ev;
   modport ctrl (output frame_len_m1, mf_len_m1, tail_en, link_en,
                 force_resync, input state, sync_n, err_cnt, ev);
   modport mon  (input frame_len_m1, mf_len_m1, tail_en, link_en,
                 force_resync, output state, sync_n, err_cnt, ev);
endinterface : jlur_mon_if

// file: verilog/jlur_sysref_gen.sv
// Purpose: Periodic and on-demand SYSREF pulse generator
// Assumes: Trigger is a level from logic on aclk
// Notes:   Pulse is one aclk cycle wide
`timescale 1ns/1ps
module jlur_sysref_gen
   import jlur_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [15:0] period,
   input  wire logic        periodic_en,
   input  wire logic        trig,
   output logic             sysref
);
   jlur_sref_st_type r_ff, nxt_r;

   // Trigger edge wins; else reload from the period counter
   always_comb begin
      nxt_r = r_ff;
      nxt_r.out = 1'b0;
      nxt_r.trig_d = trig;
      if (trig && !r_ff.trig_d) begin
         nxt_r.out = 1'b1;
         nxt_r.cnt = period;
      end else if (periodic_en) begin
         if (r_ff.cnt == 16'h0000) begin
            nxt_r.out = 1'b1;
            nxt_r.cnt = period;
         end else begin
            nxt_r.cnt = r_ff.cnt - 16'h0001;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) r_ff <= '0;
      else r_ff <= nxt_r;
   end

   assign sysref = r_ff.out;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_period_pulse: assert property (periodic_en && r_ff.cnt == 16'h0000
      |=> sysref) else $error("periodic SYSREF missed");
   a_pulse_single: assert property (sysref |=> !sysref)
      else $error("SYSREF pulse too wide");
endmodule : jlur_sysref_gen

// file: verilog/jlur_align_mon.sv
// Purpose: Frame and multiframe alignment monitor, SYNC owner
// Assumes: Decoded characters arrive on aclk, one per valid cycle
// Notes:   Replacement prediction comes from the descrambler
`timescale 1ns/1ps
module jlur_align_mon
   import jlur_pkg::*;
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   jlur_mon_if.mon         mif,
   input  wire logic       rx_valid,
   input  wire logic       rx_is_k,
   input  wire logic [7:0] rx_data,
   input  wire logic       rx_repl_predict,
   input  wire logic [3:0] rx_tail
);
   localparam jlur_mon_st_type RST = '{state: JLUR_ST_IDLE, default: '0};
   jlur_mon_st_type r_ff, nxt_r;
   logic [7:0] po;
   logic [4:0] pf;
   logic k285, isa, isf, fend, mend, misp, miss, tbad, good, bad, chk;

   // Classify the character against the tracked frame position
   always_comb begin
      nxt_r = r_ff;
      nxt_r.ev = 4'h0;
      po = (r_ff.state == JLUR_ST_ILAS) ? 8'h00 : r_ff.oct;
      pf = (r_ff.state == JLUR_ST_ILAS) ? 5'h00 : r_ff.frm;
      k285 = jlur_is_code(rx_is_k, rx_data, `JLUR_K28_5);
      isa = jlur_is_code(rx_is_k, rx_data, `JLUR_K28_3);
      isf = jlur_is_code(rx_is_k, rx_data, `JLUR_K28_7);
      fend = (po == mif.frame_len_m1);
      mend = fend && (pf == mif.mf_len_m1);
      misp = (isa && !mend) || (isf && !fend);
      // Prediction is only reliable with scrambling on both ends
      miss = rx_repl_predict && ((mend && !isa) ||
             (fend && !mend && !isf));
      tbad = mif.tail_en && fend && (rx_tail != `JLUR_TAIL_OK);
      good = (isa && mend) || (isf && fend && !mend);
      bad = misp || miss || tbad;
      chk = rx_valid && !k285 && (r_ff.state == JLUR_ST_DATA ||
            r_ff.state == JLUR_ST_ILAS);
      case (r_ff.state)
         JLUR_ST_IDLE: begin
            nxt_r.sync_n = 1'b0;
            if (mif.link_en) begin
               nxt_r.state = JLUR_ST_CGS;
               nxt_r.cgs_cnt = 3'h0;
            end
         end
         JLUR_ST_CGS: begin
            if (rx_valid) begin
               if (!k285) nxt_r.cgs_cnt = 3'h0;
               else if (r_ff.cgs_cnt == `JLUR_CGS_CNT - 3'h1) begin
                  nxt_r.sync_n = 1'b1;
                  nxt_r.state = JLUR_ST_ILAS;
               end else nxt_r.cgs_cnt = r_ff.cgs_cnt + 3'h1;
            end
         end
         JLUR_ST_ILAS, JLUR_ST_DATA: begin
            if (rx_valid && k285 && r_ff.state == JLUR_ST_DATA) begin
               // Far end restarted on its own; SYNC stays released
               nxt_r.state = JLUR_ST_CGS;
               nxt_r.cgs_cnt = 3'h0;
               nxt_r.err_cnt = 2'h0;
               nxt_r.ev[`JLUR_IRQ_REINIT] = 1'b1;
            end else if (chk) begin
               nxt_r.state = JLUR_ST_DATA;
               nxt_r.oct = fend ? 8'h00 : po + 8'h01;
               nxt_r.frm = mend ? 5'h00 : (fend ? pf + 5'h01 : pf);
               nxt_r.ev[`JLUR_IRQ_MISPL] = misp || tbad;
               nxt_r.ev[`JLUR_IRQ_MISS] = miss;
               if (bad) begin
                  if (r_ff.err_cnt == `JLUR_ERR_LIMIT - 2'h1) begin
                     nxt_r.state = JLUR_ST_CGS;
                     nxt_r.sync_n = 1'b0;
                     nxt_r.cgs_cnt = 3'h0;
                     nxt_r.err_cnt = 2'h0;
                     nxt_r.ev[`JLUR_IRQ_RESYNC] = 1'b1;
                  end else nxt_r.err_cnt = r_ff.err_cnt + 2'h1;
               end else if (good) nxt_r.err_cnt = 2'h0;
            end
         end
         default: nxt_r.state = JLUR_ST_IDLE;
      endcase
      if (mif.force_resync && r_ff.state != JLUR_ST_IDLE) begin
         nxt_r.state = JLUR_ST_CGS;
         nxt_r.sync_n = 1'b0;
         nxt_r.cgs_cnt = 3'h0;
         nxt_r.err_cnt = 2'h0;
         nxt_r.ev[`JLUR_IRQ_RESYNC] = 1'b1;
      end
      if (!mif.link_en) begin
         nxt_r.state = JLUR_ST_IDLE;
         nxt_r.sync_n = 1'b0;
         nxt_r.err_cnt = 2'h0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) r_ff <= RST;
      else r_ff <= nxt_r;
   end

   assign mif.state = r_ff.state;
   assign mif.sync_n = r_ff.sync_n;
   assign mif.err_cnt = r_ff.err_cnt;
   assign mif.ev = r_ff.ev;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_second_bad;
      chk && bad && r_ff.err_cnt == 2'h1 && mif.link_en;
   endsequence
   a_two_err_sync: assert property (s_second_bad |=>
      r_ff.state == JLUR_ST_CGS && !r_ff.sync_n)
      else $error("second alignment error did not resync");
   a_good_clears: assert property (chk && good && !bad && mif.link_en
      && !mif.force_resync |=> r_ff.err_cnt == 2'h0)
      else $error("correct character kept error count");
   a_tx_reinit: assert property (r_ff.state == JLUR_ST_DATA && rx_valid
      && k285 && mif.link_en && !mif.force_resync |=>
      r_ff.state == JLUR_ST_CGS && r_ff.sync_n)
      else $error("far-end restart not followed");
   a_sync_release: assert property ($rose(r_ff.sync_n) |->
      $past(r_ff.state) == JLUR_ST_CGS && r_ff.state == JLUR_ST_ILAS)
      else $error("SYNC released outside code sync");
   a_mispl_flag: assert property (chk && misp && mif.link_en |=>
      r_ff.ev[`JLUR_IRQ_MISPL])
      else $error("misplaced character not flagged");
endmodule : jlur_align_mon

// file: verilog/jlur_top.sv
// Purpose: Receiver-side upset-recovery controller of a JESD204B link
// Assumes: aclk 20 MHz, synchronous active-low reset, AXI4-Lite slave
// Notes:   Phase upset flag arrives on a pin and is resynchronised
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
// Contract
// - Keep SYSREF running periodically, period programmable
// - Pulse SYSREF whenever SYNC gets asserted
// - Monitor frame and multiframe alignment continuously
// - Misplaced: alignment character not at end
// - Missing: predicted alignment character absent
// - Two errors without good one: assert SYNC
// - Scrambling on both ends for recovery
// - Far-end K28.5 without SYNC: realign
// - Bad tail bits count as misalignment
// - Reinitialise oscillator after upset when syncing
module jlur_top
   import jlur_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        rx_valid,
   input  wire logic        rx_is_k,
   input  wire logic [7:0]  rx_data,
   input  wire logic        rx_repl_predict,
   input  wire logic [3:0]  rx_tail,
   input  wire logic        phase_upset_flag,
   output logic             sync_n,
   output logic             sysref,
   output logic             nco_reinit,
   output logic             irq
);
   localparam jlur_top_st_type RST = '{
      ctrl:  `JLUR_CTRL_RST,
      cfg:   `JLUR_CFG_RST,
      per:   `JLUR_PER_RST,
      imask: `JLUR_IMASK_RST,
      default: '0};

   jlur_top_st_type r_ff, nxt_r;
   jlur_mon_if      mif ();
   logic            wr;
   logic [31:0]     wd;
   logic [2:0]      widx;
   logic [2:0]      ridx;
   logic            pu_rise;
   logic [4:0]      set;
   logic [4:0]      clr;

   // Alignment monitor owns SYNC and the frame position
   jlur_align_mon u_mon (
      .aclk            (aclk),
      .aresetn         (aresetn),
      .mif             (mif.mon),
      .rx_valid        (rx_valid),
      .rx_is_k         (rx_is_k),
      .rx_data         (rx_data),
      .rx_repl_predict (rx_repl_predict),
      .rx_tail         (rx_tail)
   );

   // SYSREF fires on SYNC assertion and on every period
   jlur_sysref_gen u_sref (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .period      (r_ff.per),
      .periodic_en (r_ff.ctrl[`JLUR_CTRL_PERIOD]),
      .trig        (!mif.sync_n),
      .sysref      (sysref)
   );

   // Configuration toward the monitor
   assign mif.frame_len_m1 = r_ff.cfg[7:0];
   assign mif.mf_len_m1 = r_ff.cfg[12:8];
   assign mif.tail_en = r_ff.ctrl[`JLUR_CTRL_TAIL];
   assign mif.link_en = r_ff.ctrl[`JLUR_CTRL_EN];
   assign mif.force_resync = r_ff.ctrl[`JLUR_CTRL_RSYNC];

   // Registers, bus handshakes, pin synchroniser and events
   always_comb begin
      nxt_r = r_ff;
      clr = 5'h00;
      wr = r_ff.awv && r_ff.wv && !r_ff.bvalid;
      widx = jlur_reg_idx(r_ff.awaddr);
      ridx = jlur_reg_idx(s_axi_araddr);
      wd = jlur_merge(32'h0000_0000, r_ff.wdata, r_ff.wstrb);
      nxt_r.ctrl[`JLUR_CTRL_RSYNC] = 1'b0;
      nxt_r.ctrl[`JLUR_CTRL_NCO] = 1'b0;
      nxt_r.nco_reinit = r_ff.ctrl[`JLUR_CTRL_NCO];
      // Flag counts once the second and third stages agree
      nxt_r.pu_sy = {r_ff.pu_sy[1:0], phase_upset_flag};
      if (r_ff.pu_sy[2] == r_ff.pu_sy[1]) nxt_r.pu_lvl = r_ff.pu_sy[2];
      pu_rise = (r_ff.pu_sy[2] == r_ff.pu_sy[1]) && r_ff.pu_sy[2]
                && !r_ff.pu_lvl;
      // One reinit per upset edge; the device re-flags on sync
      if (pu_rise && r_ff.ctrl[`JLUR_CTRL_PHREQ])
         nxt_r.nco_reinit = 1'b1;
      set = {pu_rise, mif.ev};
      // Address and data are taken independently
      if (s_axi_awvalid && s_axi_awready) begin
         nxt_r.awv = 1'b1;
         nxt_r.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         nxt_r.wv = 1'b1;
         nxt_r.wdata = s_axi_wdata;
         nxt_r.wstrb = s_axi_wstrb;
      end
      if (r_ff.bvalid && s_axi_bready) nxt_r.bvalid = 1'b0;
      if (wr) begin
         nxt_r.awv = 1'b0;
         nxt_r.wv = 1'b0;
         nxt_r.bvalid = 1'b1;
         nxt_r.bresp = `JLUR_RESP_OK;
         if (widx == 3'h0) begin
            nxt_r.ctrl = 6'(jlur_merge({26'h0, r_ff.ctrl}, r_ff.wdata,
                                       r_ff.wstrb));
         end else if (widx == 3'h1) begin
            nxt_r.cfg = 13'(jlur_merge({19'h0, r_ff.cfg}, r_ff.wdata,
                                       r_ff.wstrb));
         end else if (widx == 3'h2) begin
            nxt_r.per = 16'(jlur_merge({16'h0, r_ff.per}, r_ff.wdata,
                                       r_ff.wstrb));
         end else if (widx == 3'h4) begin
            clr = wd[4:0];
         end else if (widx == 3'h5) begin
            nxt_r.imask = 5'(jlur_merge({27'h0, r_ff.imask}, r_ff.wdata,
                                        r_ff.wstrb));
         end else if (widx == 3'h3) begin
            nxt_r.bresp = `JLUR_RESP_OK;
         end else begin
            nxt_r.bresp = `JLUR_RESP_ERR;
         end
      end
      // Set wins over a write-one clear in the same cycle
      nxt_r.istat = (r_ff.istat & ~clr) | set;
      if (r_ff.rvalid && s_axi_rready) nxt_r.rvalid = 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
         nxt_r.rvalid = 1'b1;
         nxt_r.rresp = `JLUR_RESP_OK;
         nxt_r.rdata = 32'h0000_0000;
         if (ridx == 3'h0) nxt_r.rdata[5:0] = r_ff.ctrl;
         else if (ridx == 3'h1) nxt_r.rdata[12:0] = r_ff.cfg;
         else if (ridx == 3'h2) nxt_r.rdata[15:0] = r_ff.per;
         else if (ridx == 3'h3) begin
            nxt_r.rdata[3:0] = mif.state;
            nxt_r.rdata[4] = mif.sync_n;
            nxt_r.rdata[5] = r_ff.pu_lvl;
            nxt_r.rdata[9:8] = mif.err_cnt;
         end else if (ridx == 3'h4) nxt_r.rdata[4:0] = r_ff.istat;
         else if (ridx == 3'h5) nxt_r.rdata[4:0] = r_ff.imask;
         else nxt_r.rresp = `JLUR_RESP_ERR;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) r_ff <= RST;
      else r_ff <= nxt_r;
   end

   // Ready is held low while a previous answer is pending
   assign s_axi_awready = !r_ff.awv && !r_ff.bvalid;
   assign s_axi_wready = !r_ff.wv && !r_ff.bvalid;
   assign s_axi_arready = !r_ff.rvalid;
   assign s_axi_bvalid = r_ff.bvalid;
   assign s_axi_bresp = r_ff.bresp;
   assign s_axi_rvalid = r_ff.rvalid;
   assign s_axi_rdata = r_ff.rdata;
   assign s_axi_rresp = r_ff.rresp;
   assign sync_n = mif.sync_n;
   assign nco_reinit = r_ff.nco_reinit;
   assign irq = |(r_ff.istat & ~r_ff.imask);

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_sysref_on_sync: assert property ($fell(sync_n) |-> ##[1:2] sysref)
      else $error("no SYSREF after SYNC assertion");
   a_nco_auto: assert property (pu_rise && r_ff.ctrl[`JLUR_CTRL_PHREQ]
      |=> nco_reinit)
      else $error("oscillator reinit missing after upset");
   a_evt_sticky: assert property ((|set) |=>
      ((r_ff.istat & $past(set)) == $past(set)))
      else $error("event lost against clear");
   a_write_resp: assert property (wr |=> s_axi_bvalid ##0
      !s_axi_awready) else $error("write not answered");
   a_read_resp: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("read not answered");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped early");
endmodule : jlur_top

// file: tb/jlur_dev_model.sv
// Purpose: Transmitter end of the link, drives the receive character stream
// Assumes: One character per aclk, frame FM1+1 octets, multiframe KM1+1
// Notes:   inj 1 one misplaced, 2 two misplaced, 3 restart, 4 tail, 5 missing
`timescale 1ns/1ps
`include "jlur_defines.svh"
module jlur_dev_model
   import jlur_pkg::*;
#(
   parameter int FM1 = 3,
   parameter int KM1 = 31
)
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       sync_n,
   input  wire logic       sysref,
   input  wire logic [2:0] inj,
   input  wire logic       upset,
   output logic            rx_valid,
   output logic            rx_is_k,
   output logic [7:0]      rx_data,
   output logic            rx_repl_predict,
   output logic [3:0]      rx_tail,
   output logic            phase_upset_flag
);
   typedef struct packed {
      logic [7:0]  oct;
      logic [4:0]  frm;
      logic [2:0]  pend;
      logic [2:0]  cur;
      logic [2:0]  krun;
      logic [15:0] phase;
      logic        resync_event_flag;
      logic        v;
      logic        k;
      logic [7:0]  d;
      logic        p;
      logic [3:0]  t;
   } jlur_dm_st_type;
   jlur_dm_st_type st_ff;
   jlur_dm_st_type nxt_st;
   logic           end_f;
   logic           end_m;
   logic           phase_upset_flag_mask;
   logic           alarm;

   // Character scheduler; a fault request waits for the next frame start
   always_comb begin
      nxt_st = st_ff;
      end_f = st_ff.oct == 8'(FM1);
      end_m = end_f && (st_ff.frm == 5'(KM1));
      nxt_st.v = 1'b1;
      nxt_st.p = 1'b0;
      nxt_st.t = `JLUR_TAIL_OK;
      nxt_st.phase = sysref ? 16'h0000 : st_ff.phase + 16'h0001;
      if (sysref) nxt_st.resync_event_flag = 1'b1;
      if (!sync_n || st_ff.krun != 3'h0 ||
          (st_ff.cur == 3'h3 && st_ff.oct == 8'h00)) begin
         nxt_st.k = 1'b1;
         nxt_st.d = `JLUR_K28_5;
         nxt_st.oct = 8'h00;
         nxt_st.frm = 5'h00;
         nxt_st.cur = 3'h0;
         nxt_st.krun = (st_ff.cur == 3'h3) ? 3'h4 :
                       (st_ff.krun != 3'h0) ? st_ff.krun - 3'h1 : 3'h0;
      end else begin
         // Octet index stands in for scrambled payload, never a K code
         nxt_st.k = end_f;
         nxt_st.d = end_m ? `JLUR_K28_3 : end_f ? `JLUR_K28_7 : st_ff.oct;
         nxt_st.p = end_f;
         nxt_st.oct = end_f ? 8'h00 : st_ff.oct + 8'h01;
         if (end_f) nxt_st.frm = end_m ? 5'h00 : st_ff.frm + 5'h01;
         if ((st_ff.cur == 3'h1 && st_ff.oct == 8'h00) ||
             (st_ff.cur == 3'h2 && st_ff.oct < 8'h02)) begin
            nxt_st.k = 1'b1;
            nxt_st.d = `JLUR_K28_7;
         end
         if (end_f && st_ff.cur == 3'h4) nxt_st.t = 4'hF;
         if (end_f && st_ff.cur == 3'h5) nxt_st.k = 1'b0;
         if (end_f) begin
            nxt_st.cur = st_ff.pend;
            nxt_st.pend = 3'h0;
         end
      end
      if (inj != 3'h0) nxt_st.pend = inj;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) st_ff <= '0;
      else st_ff <= nxt_st;
   end

   // Flag follows the upset request; masked out of the alarm from reset
   assign phase_upset_flag = upset;
   assign phase_upset_flag_mask = 1'b1;
   assign alarm = phase_upset_flag & ~phase_upset_flag_mask;
   assign rx_valid = st_ff.v;
   assign rx_is_k = st_ff.k;
   assign rx_data = st_ff.d;
   assign rx_repl_predict = st_ff.p;
   assign rx_tail = st_ff.t;
endmodule : jlur_dev_model

// file: tb/tb.sv
// Purpose: Self-checking bench of the upset-recovery controller
// Assumes: AXI4-Lite tasks; bready and rready held high throughout
// Notes:   Sequence of register calls with expected values
`timescale 1ns/1ps
`include "jlur_defines.svh"
module tb;
   import jlur_pkg::*;
   logic aclk = 1'b0;
   logic aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, rx_valid, rx_is_k, rx_repl_predict;
   logic phase_upset_flag, sync_n, sysref, nco_reinit, irq, upset;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, rx_data;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb, rx_tail;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [2:0]  inj;
   int err_total = 0, checks = 0, srefs = 0, ncos = 0, gap = 0, lgap = 0;
   int s0;
   logic [7:0]  ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
   logic [31:0] rv [6] = '{32'h8, 32'h1F03, 32'h7FF, 32'h1, 32'h0, 32'h0};

   jlur_top u_jlur_top (.*);
   jlur_dev_model u_jlur_dev_model (.*);

   always #25 aclk = ~aclk;

   // Pulse spacing and counts, seen at the sampling edge
   always @(posedge aclk) begin
      gap <= sysref ? 1 : gap + 1;
      if (sysref) lgap <= gap;
      if (sysref) srefs <= srefs + 1;
      if (nco_reinit) ncos <= ncos + 1;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask : cyc

   // Address and data offered together, each released when taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                         input logic [1:0] er);
      logic aw, w;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      {aw, w} = 2'b11;
      while (aw || w) begin
         @(posedge aclk);
         if (s_axi_awready) aw = 1'b0;
         if (s_axi_wready) w = 1'b0;
         s_axi_awvalid <= aw;
         s_axi_wvalid <= w;
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      chk(32'(s_axi_bresp), 32'(er));
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, input logic [31:0] d,
                         input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      chk(s_axi_rdata, d);
      chk(32'(s_axi_rresp), 32'(er));
   endtask : axi_rd

   task automatic wait_sync(input logic v);
      int n;
      n = 0;
      while (sync_n !== v && n < 300) begin
         @(posedge aclk);
         n++;
      end
      chk(32'(sync_n), 32'(v));
   endtask : wait_sync

   // Fault request is picked up by the far side at its next frame start
   task automatic inject(input logic [2:0] m);
      inj <= m;
      @(posedge aclk);
      inj <= 3'h0;
      cyc(16);
   endtask : inject

   task automatic test_done;
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : test_done

   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, upset} = '0;
      {s_axi_bready, s_axi_rready} = 2'b11;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, inj} = '0;
      s_axi_wstrb = 4'hF;
      cyc(4);
      aresetn <= 1'b1;
      chk(32'(sync_n), 32'h0);
      for (int i = 0; i < 6; i++) axi_rd(ra[i], rv[i], `JLUR_RESP_OK);
      axi_rd(8'h18, 32'h0, `JLUR_RESP_ERR);
      axi_wr(8'h1C, 32'hFFFF_FFFF, `JLUR_RESP_ERR);
      axi_wr(`JLUR_A_PER, 32'h13, `JLUR_RESP_OK);
      axi_wr(`JLUR_A_CTRL, 32'h5, `JLUR_RESP_OK);
      wait_sync(1'b1);
      cyc(8);
      axi_rd(`JLUR_A_STAT, 32'h18, `JLUR_RESP_OK);
      axi_wr(`JLUR_A_ISTAT, 32'h1F, `JLUR_RESP_OK);
      inject(3'h1);
      chk(32'(sync_n), 32'h1);
      inject(3'h5);
      axi_rd(`JLUR_A_ISTAT, 32'hC, `JLUR_RESP_OK);
      chk(32'(irq), 32'h1);
      axi_wr(`JLUR_A_IMASK, 32'h1F, `JLUR_RESP_OK);
      axi_wr(`JLUR_A_ISTAT, 32'hC, `JLUR_RESP_OK);
      inject(3'h4);
      axi_rd(`JLUR_A_ISTAT, 32'h4, `JLUR_RESP_OK);
      chk(32'(irq), 32'h0);
      axi_wr(`JLUR_A_IMASK, 32'h0, `JLUR_RESP_OK);
      chk(32'(irq), 32'h1);
      axi_wr(`JLUR_A_ISTAT, 32'h4, `JLUR_RESP_OK);
      chk(32'(irq), 32'h0);
      s0 = srefs;
      inject(3'h2);
      chk(32'(srefs), 32'(s0 + 1));
      axi_rd(`JLUR_A_ISTAT, 32'h5, `JLUR_RESP_OK);
      chk(32'(sync_n), 32'h1);
      axi_wr(`JLUR_A_ISTAT, 32'h1F, `JLUR_RESP_OK);
      inject(3'h3);
      chk(32'(sync_n), 32'h1);
      axi_rd(`JLUR_A_ISTAT, 32'h2, `JLUR_RESP_OK);
      axi_wr(`JLUR_A_ISTAT, 32'h1F, `JLUR_RESP_OK);
      axi_wr(`JLUR_A_CTRL, 32'hD, `JLUR_RESP_OK);
      cyc(70);
      chk(32'(lgap), 32'd20);
      axi_wr(`JLUR_A_CTRL, 32'h11, `JLUR_RESP_OK);
      upset <= 1'b1;
      cyc(10);
      chk(32'(ncos), 32'h1);
      axi_rd(`JLUR_A_ISTAT, 32'h10, `JLUR_RESP_OK);
      axi_wr(`JLUR_A_CTRL, 32'h31, `JLUR_RESP_OK);
      cyc(4);
      chk(32'(ncos), 32'h2);
      upset <= 1'b0;
      s0 = srefs;
      axi_wr(`JLUR_A_CTRL, 32'h3, `JLUR_RESP_OK);
      cyc(16);
      chk(32'(srefs), 32'(s0 + 1));
      wait_sync(1'b1);
      test_done();
   end

   // Whole sequence needs well under two thousand cycles
   initial begin
      cyc(6000);
      err_total++;
      test_done();
   end
endmodule : tb
